// file: bench/preg_link_monitor.sv
// Concurrent checks on the process image link
`timescale 1ns/10ps
module preg_link_monitor
  import preg_pkg::*;
(
  input wire logic       clk,
  input wire logic       reset,
  input wire logic [7:0] ctrl_byte,
  input wire logic [7:0] out_hi,
  input wire logic [7:0] out_lo,
  input wire logic [7:0] status_byte,
  input wire logic [7:0] in_hi,
  input wire logic [7:0] in_lo
);
  logic [15:0] shadow [64];
  logic        unl;
  logic [15:0] rd_val;
  logic [5:0]  num;
  wire logic   wr = ctrl_byte[7] & ctrl_byte[6];
  wire logic   rdq = ctrl_byte[7] & ~ctrl_byte[6];
  assign num = ctrl_byte[5:0];
  assign rd_val = shadow[num];
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);
  // Reference bank, key register always writable
  always_ff @(posedge clk) begin
    if (reset) begin
      unl <= 1'b0;
      for (int i = 0; i < 64; i++) shadow[i] <= 16'h0000;
    end else if (wr && (num == REG_KEY || unl)) begin
      shadow[num] <= {out_hi, out_lo};
      if (num == REG_KEY) unl <= ({out_hi, out_lo} == UNLOCK_KEY);
    end
  end
  chk_write_ack: assert property (
    wr |=> status_byte == ($past(ctrl_byte) & 8'hBF))
    else $error("bad write ack");
  chk_read_ack: assert property (
    rdq |=> status_byte == $past(ctrl_byte))
    else $error("bad read ack");
  chk_idle_status: assert property (
    !ctrl_byte[7] |=> status_byte == 8'h00)
    else $error("status not idle");
  chk_num_echo: assert property (
    ctrl_byte[7] [*2] |-> ##1 status_byte[5:0] == $past(num))
    else $error("number not echoed");
  chk_key_read: assert property (
    ctrl_byte == 8'h9F |=> {in_hi, in_lo} == $past(rd_val))
    else $error("bad key readback");
  chk_feature_read: assert property (
    ctrl_byte == 8'hA0 |=> {in_hi, in_lo} == $past(rd_val))
    else $error("bad feature readback");
  chk_locked_bank: assert property (
    rdq && num > REG_FEATURE |=> {in_hi, in_lo} == $past(rd_val))
    else $error("protected register changed");
  chk_in_hold: assert property (
    !rdq |=> $stable(in_hi) && $stable(in_lo))
    else $error("input word moved");
endmodule : preg_link_monitor

// file: bench/process_image_register_access_tb_top.sv
// Bench: APB-driven host and device joined over the link
`timescale 1ns/10ps
module process_image_register_access_tb_top;
  import preg_pkg::*;
  logic        clk = 1'b0;
  logic        reset = 1'b1;
  logic        power_cycle = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        err_seen;
  logic        write_unlocked;
  logic [15:0] active_feature;
  logic [31:0] rd;
  int          n_fail = 0;
  int          tests_run = 0;
  preg_link_if link ();
  preg_host preg_host_inst (.clk(clk), .reset(reset), .link(link.host),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr));
  preg_device preg_device_inst (.clk(clk), .reset(reset),
    .link(link.device), .power_cycle(power_cycle),
    .write_unlocked(write_unlocked), .active_feature(active_feature));
  preg_link_monitor preg_link_monitor_inst (.clk(clk), .reset(reset),
    .ctrl_byte(link.ctrl_byte), .out_hi(link.out_hi),
    .out_lo(link.out_lo), .status_byte(link.status_byte),
    .in_hi(link.in_hi), .in_lo(link.in_lo));
  always #2.5 clk = ~clk;
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value at %0t: saw %h, want %h", $time, seen, exp);
    end
  endtask : check
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    err_seen = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // One link access; ack and read word compared
  task automatic op(input logic [7:0] c, input logic [15:0] d,
                    input logic [7:0] ack, input logic [15:0] e);
    apb(1'b1, APB_WDATA, {16'h0000, d});
    apb(1'b1, APB_CMD, {24'h000000, c});
    do apb(1'b0, APB_STATUS, 32'h0); while (rd[ST_BUSY_BIT] !== 1'b0);
    check(rd, {24'h000000, ack});
    if (!c[6]) begin
      apb(1'b0, APB_RDATA, 32'h0);
      check(rd, {16'h0000, e});
    end
  endtask : op
  task automatic test_done;
    $display("checks %0d, mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : test_done
  initial begin
    #20000;
    n_fail++;
    test_done();
  end
  initial begin
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    op(8'hE1, 16'h1111, 8'hA1, 16'h0);
    op(8'hA1, 16'hFFFF, 8'hA1, 16'h0);
    op(8'hE0, 16'hAAAA, 8'hA0, 16'h0);
    op(8'hA0, 16'hFFFF, 8'hA0, 16'h0);
    op(8'hDF, 16'h1235, 8'h9F, 16'h0);
    check({31'h0, write_unlocked}, 32'h1);
    op(8'h9F, 16'hFFFF, 8'h9F, 16'h1235);
    op(8'hE0, 16'h0002, 8'hA0, 16'h0);
    op(8'hA0, 16'hFFFF, 8'hA0, 16'h0002);
    check({16'h0, active_feature}, 32'h0);
    @(posedge clk) power_cycle <= 1'b1;
    @(posedge clk) power_cycle <= 1'b0;
    @(posedge clk);
    check({16'h0, active_feature}, 32'h2);
    op(8'hDF, 16'h1236, 8'h9F, 16'h0);
    check({31'h0, write_unlocked}, 32'h0);
    op(8'hE0, 16'h5555, 8'hA0, 16'h0);
    op(8'hA0, 16'hFFFF, 8'hA0, 16'h0002);
    apb(1'b0, APB_WDATA, 32'h0);
    check(rd, 32'h0000FFFF);
    // Second command while busy is refused and dropped
    apb(1'b1, APB_CMD, 32'h00000020);
    check({31'h0, err_seen}, 32'h0);
    apb(1'b1, APB_CMD, 32'h00000061);
    check({31'h0, err_seen}, 32'h1);
    apb(1'b0, APB_CMD, 32'h0);
    check(rd, 32'h000000A0);
    do apb(1'b0, APB_STATUS, 32'h0); while (rd[ST_BUSY_BIT] !== 1'b0);
    check(rd, 32'h000002A0);
    apb(1'b0, APB_RDATA, 32'h0);
    check(rd, 32'h00000002);
    op(8'hDF, 16'h0000, 8'h9F, 16'h0);
    apb(1'b0, 8'h10, 32'h0);
    check(rd, 32'h0);
    test_done();
  end
endmodule : process_image_register_access_tb_top

// file: verilog/preg_device.sv
// Device end: register bank behind the process image
`timescale 1ns/10ps
module preg_device (
  input  wire logic         clk,
  input  wire logic         reset,
  preg_link_if.device       link,
  input  wire logic         power_cycle,
  output logic              write_unlocked,
  output logic [15:0]       active_feature
);
  import preg_pkg::*;

  // ****************************************************************
  // Register bank
  // ****************************************************************
  logic [15:0] regs      [NUM_REGS];
  logic [15:0] next_regs [NUM_REGS];
  logic        unlocked;
  logic        next_unlocked;
  logic [15:0] applied;
  logic [15:0] next_applied;
  logic [7:0]  stat;
  logic [7:0]  next_stat;
  logic [15:0] rword;
  logic [15:0] next_rword;
  logic [5:0]  num;
  logic [15:0] wval;
  logic        req;
  logic        wr;

  assign num  = link.ctrl_byte[NUM_W-1:0];
  assign wval = {link.out_hi, link.out_lo};
  assign req  = link.ctrl_byte[REQ_BIT];
  assign wr   = link.ctrl_byte[DIR_BIT];

  always_comb begin
    next_regs     = regs;
    next_unlocked = unlocked;
    next_applied  = applied;
    next_stat     = BYTE_RESET;
    next_rword    = rword;
    if (power_cycle) begin
      next_applied = regs[REG_FEATURE];
    end
    if (req) begin
      if (wr) begin
        if (num == REG_KEY) begin
          next_regs[REG_KEY] = wval;
          next_unlocked = (wval == UNLOCK_KEY);
        end else if (unlocked) begin
          next_regs[num] = wval;
        end
        next_stat = ack_of(link.ctrl_byte);
      end else begin
        next_rword = regs[num];
        next_stat  = ack_of(link.ctrl_byte);
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      for (int i = 0; i < NUM_REGS; i++) begin
        regs[i] <= REG_RESET;
      end
      unlocked <= 1'b0;
      applied  <= REG_RESET;
      stat     <= BYTE_RESET;
      rword    <= REG_RESET;
    end else begin
      regs     <= next_regs;
      unlocked <= next_unlocked;
      applied  <= next_applied;
      stat     <= next_stat;
      rword    <= next_rword;
    end
  end

  assign link.status_byte = stat;
  assign link.in_hi       = rword[15:8];
  assign link.in_lo       = rword[7:0];
  assign write_unlocked   = unlocked;
  assign active_feature   = applied;

endmodule : preg_device

// file: verilog/preg_host.sv
// Host end: APB-driven controller issuing register accesses
//
// The APB interface to the registers was decided locally.
`timescale 1ns/10ps
module preg_host (
  input  wire logic         clk,
  input  wire logic         reset,
  preg_link_if.host         link,
  input  wire logic         psel,
  input  wire logic         penable,
  input  wire logic         pwrite,
  input  wire logic [7:0]   paddr,
  input  wire logic [31:0]  pwdata,
  output logic [31:0]       prdata,
  output logic              pready,
  output logic              pslverr
);
  import preg_pkg::*;

  // ****************************************************************
  // Command registers and link sequencer
  // ****************************************************************
  host_state_t state, next_state;
  logic [7:0]  cmd, next_cmd;
  logic [15:0] wdat, next_wdat;
  logic [15:0] rdat, next_rdat;
  logic [7:0]  last_stat, next_last_stat;
  logic        err, next_err;
  logic [7:0]  ctrl, next_ctrl;
  logic [31:0] rd, next_rd;
  logic        rdy, next_rdy;
  logic        slverr, next_slverr;
  logic        acc;
  logic        fin;

  // Access phase seen, answer due next edge
  assign acc = psel && penable && !rdy;
  // Writes land at the edge that completes the transfer
  assign fin = psel && penable && rdy && pwrite;

  always_comb begin
    next_state     = state;
    next_cmd       = cmd;
    next_wdat      = wdat;
    next_rdat      = rdat;
    next_last_stat = last_stat;
    next_err       = err;
    next_ctrl      = ctrl;
    next_rd        = rd;
    next_rdy       = acc;
    // Command while a link access runs is refused
    next_slverr    = acc && pwrite && paddr == APB_CMD && state != h_idle;
    if (fin) begin
      if (paddr == APB_WDATA) begin
        next_wdat = pwdata[15:0];
      end else if (paddr == APB_CMD && !slverr) begin
        next_cmd   = pwdata[7:0] | 8'h80;
        next_err   = 1'b0;
        next_state = h_send;
      end else if (paddr == APB_CMD) begin
        next_err = 1'b1;
      end
    end
    if (acc && !pwrite) begin
      case (paddr)
        APB_CMD:    next_rd = {24'h000000, cmd};
        APB_WDATA:  next_rd = {16'h0000, wdat};
        APB_STATUS: next_rd = {22'h000000, err, state != h_idle, last_stat};
        APB_RDATA:  next_rd = {16'h0000, rdat};
        default:    next_rd = 32'h00000000;
      endcase
    end
    case (state)
      h_idle: next_ctrl = BYTE_RESET;
      h_send: begin
        next_ctrl  = cmd;
        next_state = h_wait;
      end
      h_wait: begin
        if (link.status_byte == ack_of(cmd) && ctrl == cmd) begin
          next_last_stat = link.status_byte;
          if (!cmd[DIR_BIT]) begin
            next_rdat = {link.in_hi, link.in_lo};
          end
          next_ctrl  = BYTE_RESET;
          next_state = h_drop;
        end
      end
      h_drop: begin
        next_ctrl = BYTE_RESET;
        if (link.status_byte == BYTE_RESET) begin
          next_state = h_idle;
        end
      end
      default: next_state = h_idle;
    endcase
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      state     <= h_idle;
      cmd       <= BYTE_RESET;
      wdat      <= REG_RESET;
      rdat      <= REG_RESET;
      last_stat <= BYTE_RESET;
      err       <= 1'b0;
      ctrl      <= BYTE_RESET;
      rd        <= 32'h00000000;
      rdy       <= 1'b0;
      slverr    <= 1'b0;
    end else begin
      state     <= next_state;
      cmd       <= next_cmd;
      wdat      <= next_wdat;
      rdat      <= next_rdat;
      last_stat <= next_last_stat;
      err       <= next_err;
      ctrl      <= next_ctrl;
      rd        <= next_rd;
      rdy       <= next_rdy;
      slverr    <= next_slverr;
    end
  end

  assign link.ctrl_byte = ctrl;
  assign link.out_hi    = wdat[15:8];
  assign link.out_lo    = wdat[7:0];
  assign prdata         = rd;
  assign pready         = rdy;
  assign pslverr        = slverr;

endmodule : preg_host

// file: verilog/preg_link_if.sv
// Cyclic process image link between host and device
`timescale 1ns/10ps
interface preg_link_if;
  logic [7:0] ctrl_byte;
  logic [7:0] out_hi;
  logic [7:0] out_lo;
  logic [7:0] status_byte;
  logic [7:0] in_hi;
  logic [7:0] in_lo;

  modport host (
    output ctrl_byte,
    output out_hi,
    output out_lo,
    input  status_byte,
    input  in_hi,
    input  in_lo
  );

  modport device (
    input  ctrl_byte,
    input  out_hi,
    input  out_lo,
    output status_byte,
    output in_hi,
    output in_lo
  );
endinterface : preg_link_if

// file: verilog/preg_pkg.sv
// Shared constants and types for cyclic process-image register access
//
// Overview of operation
// - User registers read-only except register 31
// - Key 0x1235 in register 31 unlocks writes
// - Any other key value relocks writes
// - Writes stored, applied only after restart
// - Control bit 7 requests register access
// - Control bit 6 set means write
// - Control bits 5..0 carry register number
// - Data word sent high byte first
// - Host supplies write value in data word
// - Device ignores host data on reads
// - Write acknowledged with bit 6 cleared
// - Host discards data after write acknowledge
// - Read acknowledged with unchanged control byte
// - Reading register 31 returns current key
// - Reading register 32 returns feature configuration
// - Host writes 0x0000 to 31 afterwards
package preg_pkg;

  // ****************************************************************
  // Control byte fields, register numbers, keys and reset values
  // ****************************************************************
  localparam int        REQ_BIT       = 7;
  localparam int        DIR_BIT       = 6;
  localparam int        NUM_W         = 6;
  localparam int        NUM_REGS      = 64;
  localparam logic [5:0] REG_KEY      = 6'h1F;
  localparam logic [5:0] REG_FEATURE  = 6'h20;
  localparam logic [15:0] UNLOCK_KEY  = 16'h1235;
  localparam logic [15:0] LOCK_KEY    = 16'h0000;
  localparam logic [15:0] REG_RESET   = 16'h0000;
  localparam logic [7:0]  BYTE_RESET  = 8'h00;

  // ****************************************************************
  // Host controller register map (APB, byte addresses)
  // ****************************************************************
  localparam logic [7:0] APB_CMD      = 8'h00;
  localparam logic [7:0] APB_WDATA    = 8'h04;
  localparam logic [7:0] APB_STATUS   = 8'h08;
  localparam logic [7:0] APB_RDATA    = 8'h0C;
  localparam int         ST_BUSY_BIT  = 8;
  localparam int         ST_ERR_BIT   = 9;

  typedef enum logic [1:0] {
    h_idle,
    h_send,
    h_wait,
    h_drop
  } host_state_t;

  // Acknowledge expected for a given control byte
  function automatic logic [7:0] ack_of(input logic [7:0] ctrl);
    ack_of = ctrl[DIR_BIT] ? (ctrl & 8'hBF) : ctrl;
  endfunction : ack_of

endpackage : preg_pkg
